// file: hdl/mcheck_pkg.sv
package mcheck_pkg;

   // =========================================================
   // frame layout
   localparam int FRAME_WORDS = 9;
   localparam logic [31:0] FRAME_BYTE_COUNT = 32'h0000_0018;
   localparam logic [7:0] OFF_COUNT = 8'h00;
   localparam logic [7:0] OFF_CODE = 8'h04;
   localparam logic [7:0] OFF_VADDR = 8'h08;
   localparam logic [7:0] OFF_VIBA = 8'h0C;
   localparam logic [7:0] OFF_INTR = 8'h10;
   localparam logic [7:0] OFF_INTERNAL = 8'h14;
   localparam logic [7:0] OFF_IREG = 8'h18;
   localparam logic [7:0] OFF_PC = 8'h1C;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] WORD_BYTES = 8'h04;

   // =========================================================
   // error codes
   localparam logic [7:0] CODE_FP_XFER = 8'h01;
   localparam logic [7:0] CODE_FP_RSVD = 8'h02;
   localparam logic [7:0] CODE_FP_OPPAR = 8'h03;
   localparam logic [7:0] CODE_FP_STAT = 8'h04;
   localparam logic [7:0] CODE_FP_RESPAR = 8'h05;
   localparam logic [7:0] CODE_TB_MISS = 8'h08;
   localparam logic [7:0] CODE_TB_HIT = 8'h09;
   localparam logic [7:0] CODE_INTERRUPT_IDENTIFIER = 8'h0A;
   localparam logic [7:0] CODE_STR_MOVE = 8'h0B;
   localparam logic [7:0] CODE_TRAP = 8'h0C;
   localparam logic [7:0] CODE_CS_ADDR = 8'h0D;
   localparam logic [7:0] CODE_CACHE_PAR = 8'h10;
   localparam logic [7:0] CODE_BUS_RD = 8'h11;
   localparam logic [7:0] CODE_BUS_WR = 8'h12;
   localparam logic [7:0] CODE_BUS_TRAP = 8'h13;
   localparam logic [7:0] CODE_VECTOR = 8'h14;
   localparam logic [7:0] CODE_ISTREAM = 8'h15;
   localparam int NUM_FAULTS = 17;

   // =========================================================
   // captured processor state
   typedef struct packed {
      logic [31:0] vaddr;
      logic [31:0] viba;
      logic [31:0] intr_state;
      logic [31:0] internal_state;
      logic [31:0] internal_reg;
      logic [31:0] inst_pc;
      logic [31:0] status;
   } cpu_state_s;

   typedef struct packed {
      logic valid;
      logic [7:0] offset;
      logic [31:0] data;
   } frame_word_s;

endpackage : mcheck_pkg

// file: hdl/fault_encoder.sv
`timescale 1ns/1ns
`default_nettype none
// =========================================================
// fixed priority fault encoder, lowest index wins
module fault_encoder #(
   parameter int N = mcheck_pkg::NUM_FAULTS
) (
   input wire logic [N-1:0] fault,
   output logic hit,
   output logic [7:0] code
);
   localparam logic [7:0] CODES [mcheck_pkg::NUM_FAULTS] = '{
      mcheck_pkg::CODE_FP_XFER, mcheck_pkg::CODE_FP_RSVD, mcheck_pkg::CODE_FP_OPPAR,
      mcheck_pkg::CODE_FP_STAT, mcheck_pkg::CODE_FP_RESPAR, mcheck_pkg::CODE_TB_MISS,
      mcheck_pkg::CODE_TB_HIT, mcheck_pkg::CODE_INTERRUPT_IDENTIFIER, mcheck_pkg::CODE_STR_MOVE,
      mcheck_pkg::CODE_TRAP, mcheck_pkg::CODE_CS_ADDR, mcheck_pkg::CODE_CACHE_PAR,
      mcheck_pkg::CODE_BUS_RD, mcheck_pkg::CODE_BUS_WR, mcheck_pkg::CODE_BUS_TRAP,
      mcheck_pkg::CODE_VECTOR, mcheck_pkg::CODE_ISTREAM};

   always_comb begin
      hit = 1'b0;
      code = mcheck_pkg::CODE_FP_XFER;
      for (int i = N - 1; i >= 0; i--) begin
         if (fault[i]) begin
            hit = 1'b1;
            code = CODES[i];
         end
      end
   end
endmodule : fault_encoder
`default_nettype wire

// file: hdl/frame_store.sv
`timescale 1ns/1ns
`default_nettype none
// =========================================================
// frame memory, registered read port
module frame_store #(
   parameter int DEPTH = mcheck_pkg::FRAME_WORDS
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : frame_store
`default_nettype wire

// file: hdl/machine_check_frame.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - frame top holds byte count 18
// - error code at stack pointer plus four
// - codes 01 transfer, 02 reserved instruction
// - operand parity error gives code 03
// - unknown accelerator status gives code 04
// - result parity error gives code 05
// - buffer miss in translation flow: 08
// - buffer hit in translation flow: 09
// - codes 0A, 0B, 0C for undefined states
// - undefined control store address gives 0D
// - cache read parity error gives 10
// - bus read or parity error: 11
// - bus write or buffer clear error: 12
// - bus microtrap 13, vector error 14
// - instruction stream read error gives 15
// - plus eight holds virtual address pointer
// - saved pc is instruction start address
// - last word holds status longword
module machine_check_frame (
   input wire logic clk,
   input wire logic rst,
   input wire logic fp_xfer_err,
   input wire logic fp_rsvd_inst,
   input wire logic fp_operand_par,
   input wire logic fp_unknown_status,
   input wire logic fp_result_par,
   input wire logic tb_miss_in_flow,
   input wire logic tb_hit_in_flow,
   input wire logic bad_interrupt_identifier,
   input wire logic bad_string_move_state,
   input wire logic bad_trap_code,
   input wire logic bad_cs_addr,
   input wire logic cache_read_par,
   input wire logic bus_read_err,
   input wire logic bus_write_err,
   input wire logic bus_microtrap,
   input wire logic vector_err,
   input wire logic istream_read_err,
   input wire mcheck_pkg::cpu_state_s cpu_state,
   input wire logic frame_ack,
   input wire logic [3:0] read_index,
   output logic busy,
   output mcheck_pkg::frame_word_s frame_word,
   output logic frame_done,
   output logic [7:0] last_code,
   output logic [31:0] read_data
);
   // =========================================================
   // fault intake
   typedef enum {IDLE, PUSH, WAIT_ACK} state_e;

   logic [mcheck_pkg::NUM_FAULTS-1:0] faults;
   logic hit;
   logic [7:0] code;

   assign faults = {istream_read_err,
                    vector_err,
                    bus_microtrap,
                    bus_write_err,
                    bus_read_err,
                    cache_read_par,
                    bad_cs_addr,
                    bad_trap_code,
                    bad_string_move_state,
                    bad_interrupt_identifier,
                    tb_hit_in_flow,
                    tb_miss_in_flow,
                    fp_result_par,
                    fp_unknown_status,
                    fp_operand_par,
                    fp_rsvd_inst,
                    fp_xfer_err};

   fault_encoder #(.N(mcheck_pkg::NUM_FAULTS)) u_enc (
      .fault(faults),
      .hit(hit),
      .code(code)
   );

   // =========================================================
   // frame sequencer
   state_e state, next_state;
   logic [3:0] idx, next_idx;
   logic [7:0] held_code, next_held_code;
   mcheck_pkg::cpu_state_s snap, next_snap;
   mcheck_pkg::frame_word_s next_frame_word;
   logic [7:0] next_last_code;
   logic next_frame_done;
   logic [31:0] word_data;
   logic store_we;

   // snapshot taken on the detect cycle so later state changes can't leak in
   always_comb begin
      unique case (idx)
         4'h0: word_data = mcheck_pkg::FRAME_BYTE_COUNT;
         4'h1: word_data = {24'h0, held_code};
         4'h2: word_data = snap.vaddr;
         4'h3: word_data = snap.viba;
         4'h4: word_data = snap.intr_state;
         4'h5: word_data = snap.internal_state;
         4'h6: word_data = snap.internal_reg;
         4'h7: word_data = snap.inst_pc;
         default: word_data = snap.status;
      endcase
   end

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_held_code = held_code;
      next_snap = snap;
      next_frame_word = '0;
      next_frame_done = 1'b0;
      next_last_code = last_code;
      unique case (state)
         IDLE: begin
            // only encoder hits reach the frame; reserved codes cannot arise
            if (hit) begin
               next_state = PUSH;
               next_idx = '0;
               next_held_code = code;
               next_snap = cpu_state;
            end
         end
         PUSH: begin
            next_frame_word.valid = 1'b1;
            next_frame_word.offset = 8'(idx) * mcheck_pkg::WORD_BYTES;
            next_frame_word.data = word_data;
            if (idx == 4'(mcheck_pkg::FRAME_WORDS - 1)) begin
               next_state = WAIT_ACK;
               next_frame_done = 1'b1;
               next_last_code = held_code;
            end else begin
               next_idx = idx + 4'h1;
            end
         end
         WAIT_ACK: begin
            // faults during handling are dropped: one frame at a time
            if (frame_ack) begin
               next_state = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= IDLE;
         idx <= '0;
         held_code <= '0;
         snap <= '0;
         frame_word <= '0;
         frame_done <= 1'b0;
         last_code <= '0;
      end else begin
         state <= next_state;
         idx <= next_idx;
         held_code <= next_held_code;
         snap <= next_snap;
         frame_word <= next_frame_word;
         frame_done <= next_frame_done;
         last_code <= next_last_code;
      end
   end

   assign busy = (state != IDLE);
   assign store_we = (state == PUSH);

   frame_store #(.DEPTH(mcheck_pkg::FRAME_WORDS)) u_store (
      .clk(clk),
      .we(store_we),
      .waddr(idx),
      .wdata(word_data),
      .raddr(read_index),
      .rdata(read_data)
   );

   // =========================================================
   // checks: frame words
   // word n of the frame shows n+2 edges after the fault is taken
   count_word_a: assert property (@(posedge clk) disable iff (rst)
      frame_word.valid && frame_word.offset == mcheck_pkg::OFF_COUNT
      |-> frame_word.data == mcheck_pkg::FRAME_BYTE_COUNT)
      else $error("byte count word wrong");
   code_word_a: assert property (@(posedge clk) disable iff (rst)
      frame_word.valid && frame_word.offset == mcheck_pkg::OFF_CODE
      |-> frame_word.data == {24'h0, held_code})
      else $error("code word wrong");
   vaddr_word_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && hit |=> ##3 frame_word.offset == mcheck_pkg::OFF_VADDR
      && frame_word.data == $past(cpu_state.vaddr, 4))
      else $error("address word wrong");
   pc_word_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && hit |=> ##8 frame_word.offset == mcheck_pkg::OFF_PC
      && frame_word.data == $past(cpu_state.inst_pc, 9))
      else $error("pc word wrong");
   status_word_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && hit |=> ##9 frame_done && frame_word.offset == mcheck_pkg::OFF_STATUS
      && frame_word.data == $past(cpu_state.status, 10))
      else $error("status word wrong");
   done_last_a: assert property (@(posedge clk) disable iff (rst)
      frame_done
      |-> frame_word.valid && frame_word.offset == mcheck_pkg::OFF_STATUS)
      else $error("done not on last word");
   done_pulse_a: assert property (@(posedge clk) disable iff (rst)
      frame_done
      |=> !frame_done)
      else $error("done longer than one cycle");
   offset_step_a: assert property (@(posedge clk) disable iff (rst)
      frame_word.valid && !frame_done |=> frame_word.valid
      && frame_word.offset == $past(frame_word.offset) + mcheck_pkg::WORD_BYTES)
      else $error("frame offsets out of order");

   // =========================================================
   // checks: error codes, lower code wins when faults coincide
   fp_xfer_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && fp_xfer_err
      |=> held_code == mcheck_pkg::CODE_FP_XFER)
      else $error("transfer error code wrong");
   fp_rsvd_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && fp_rsvd_inst && faults[0] == 1'b0
      |=> held_code == mcheck_pkg::CODE_FP_RSVD)
      else $error("reserved instruction code wrong");
   fp_oppar_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && fp_operand_par && faults[1:0] == 2'b00
      |=> held_code == mcheck_pkg::CODE_FP_OPPAR)
      else $error("operand parity code wrong");
   fp_stat_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && fp_unknown_status && faults[2:0] == 3'h0
      |=> held_code == mcheck_pkg::CODE_FP_STAT)
      else $error("unknown status code wrong");
   fp_respar_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && fp_result_par && faults[3:0] == 4'h0
      |=> held_code == mcheck_pkg::CODE_FP_RESPAR)
      else $error("result parity code wrong");
   tb_miss_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && tb_miss_in_flow && faults[4:0] == 5'h00
      |=> held_code == mcheck_pkg::CODE_TB_MISS)
      else $error("buffer miss code wrong");
   tb_hit_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && tb_hit_in_flow && faults[5:0] == 6'h00
      |=> held_code == mcheck_pkg::CODE_TB_HIT)
      else $error("buffer hit code wrong");
   interrupt_identifier_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bad_interrupt_identifier && faults[6:0] == 7'h00
      |=> held_code == mcheck_pkg::CODE_INTERRUPT_IDENTIFIER)
      else $error("interrupt identifier code wrong");
   str_move_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bad_string_move_state && faults[7:0] == 8'h00
      |=> held_code == mcheck_pkg::CODE_STR_MOVE)
      else $error("string move code wrong");
   trap_code_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bad_trap_code && faults[8:0] == 9'h000
      |=> held_code == mcheck_pkg::CODE_TRAP)
      else $error("trap code wrong");
   cs_addr_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bad_cs_addr && faults[9:0] == '0
      |=> held_code == mcheck_pkg::CODE_CS_ADDR)
      else $error("control store code wrong");
   cache_par_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && cache_read_par && faults[10:0] == 11'h000
      |=> held_code == mcheck_pkg::CODE_CACHE_PAR)
      else $error("cache parity code wrong");
   bus_read_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bus_read_err && faults[11:0] == 12'h000
      |=> held_code == mcheck_pkg::CODE_BUS_RD)
      else $error("bus read code wrong");
   bus_write_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bus_write_err && faults[12:0] == 13'h0000
      |=> held_code == mcheck_pkg::CODE_BUS_WR)
      else $error("bus write code wrong");
   bus_trap_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && bus_microtrap && faults[13:0] == 14'h0000
      |=> held_code == mcheck_pkg::CODE_BUS_TRAP)
      else $error("bus microtrap code wrong");
   vector_code_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && vector_err && faults[14:0] == 15'h0000
      |=> held_code == mcheck_pkg::CODE_VECTOR)
      else $error("vector code wrong");
   istream_code_a: assert property (@(posedge clk) disable iff (rst)
      state == IDLE && faults == 17'h10000
      |=> held_code == mcheck_pkg::CODE_ISTREAM)
      else $error("istream code wrong");
   no_reserved_a: assert property (@(posedge clk) disable iff (rst)
      frame_done
      |-> last_code inside {[8'h01:8'h05], [8'h08:8'h0D], [8'h10:8'h15]})
      else $error("reserved code written");

   // =========================================================
   // checks: busy and acknowledge
   valid_busy_a: assert property (@(posedge clk) disable iff (rst)
      frame_word.valid
      |-> busy)
      else $error("frame word while idle");
   ack_release_a: assert property (@(posedge clk) disable iff (rst)
      state == WAIT_ACK && frame_ack
      |=> !busy)
      else $error("busy after acknowledge");
   ack_wait_a: assert property (@(posedge clk) disable iff (rst)
      state == WAIT_ACK && !frame_ack
      |=> busy)
      else $error("busy dropped without acknowledge");
   code_hold_a: assert property (@(posedge clk) disable iff (rst)
      busy
      |=> $stable(held_code))
      else $error("code changed while busy");
endmodule : machine_check_frame
`default_nettype wire

// file: test/machine_check_frame_bench.sv
`timescale 1ns/1ns
`default_nettype none
module machine_check_frame_bench;
   // =========================================================
   // clock, reset and stimulus
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [16:0] faults = 17'h0;
   mcheck_pkg::cpu_state_s cpu_state = '0;
   logic frame_ack = 1'b0;
   logic [3:0] read_index = 4'h0;
   logic busy;
   mcheck_pkg::frame_word_s frame_word;
   logic frame_done;
   logic [7:0] last_code;
   logic [31:0] read_data;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] seed = 32'hA82B;
   // fault order equals the encoder priority, lowest first
   logic [7:0] code_tab [17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A,
      8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};

   always #4 clk = ~clk;

   machine_check_frame dut_u (
      .clk(clk), .rst(rst),
      .fp_xfer_err(faults[0]), .fp_rsvd_inst(faults[1]), .fp_operand_par(faults[2]),
      .fp_unknown_status(faults[3]), .fp_result_par(faults[4]),
      .tb_miss_in_flow(faults[5]), .tb_hit_in_flow(faults[6]),
      .bad_interrupt_identifier(faults[7]), .bad_string_move_state(faults[8]),
      .bad_trap_code(faults[9]), .bad_cs_addr(faults[10]), .cache_read_par(faults[11]),
      .bus_read_err(faults[12]), .bus_write_err(faults[13]), .bus_microtrap(faults[14]),
      .vector_err(faults[15]), .istream_read_err(faults[16]),
      .cpu_state(cpu_state), .frame_ack(frame_ack), .read_index(read_index),
      .busy(busy), .frame_word(frame_word), .frame_done(frame_done),
      .last_code(last_code), .read_data(read_data)
   );

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // =========================================================
   // comparisons and closing
   task automatic mismatch(input string what);
      failures++;
      $display("unexpected at %0t: %s", $time, what);
   endtask : mismatch

   task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) mismatch($sformatf("%s got %h want %h", what, got, exp));
   endtask : check_data

   task automatic check_word(input mcheck_pkg::frame_word_s exp);
      checks_done++;
      if (frame_word !== exp) mismatch($sformatf("word got %h want %h", frame_word, exp));
   endtask : check_word

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatch("run too long");
         end_of_test();
      end
   end

   // =========================================================
   // one frame: present faults, stream, read back, acknowledge
   task automatic run_frame(input logic [16:0] fv, input logic [16:0] late, input string name);
      logic [31:0] exp [9];
      logic [7:0] code;
      mcheck_pkg::cpu_state_s st;
      int n;
      begin
         code = 8'h00;
         for (int i = 16; i >= 0; i--) if (fv[i]) code = code_tab[i];
         st = {xs(), xs(), xs(), xs(), xs(), xs(), xs()};
         exp = '{mcheck_pkg::FRAME_BYTE_COUNT, {24'h0, code}, st.vaddr, st.viba, st.intr_state,
            st.internal_state, st.internal_reg, st.inst_pc, st.status};
         cpu_state = st;
         faults = fv;
         @(negedge clk);
         // state changes after capture must not reach the frame
         cpu_state = {xs(), xs(), xs(), xs(), xs(), xs(), xs()};
         faults = late;
         n = 0;
         while (frame_word.valid !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
         end
         if (n == 6) mismatch("no frame");
         for (int k = 0; k < 9; k++) begin
            check_word('{1'b1, 8'(k * 4), exp[k]});
            check_data({31'h0, frame_done}, {31'h0, k == 8}, "done");
            check_data({31'h0, busy}, 32'h1, "busy in frame");
            @(negedge clk);
         end
         check_data({24'h0, last_code}, {24'h0, code}, "code");
         for (int k = 0; k < 9; k++) begin
            read_index = 4'(k);
            @(negedge clk);
            check_data(read_data, exp[k], "readback");
         end
         faults = 17'h0;
         frame_ack = 1'b1;
         @(negedge clk);
         frame_ack = 1'b0;
         @(negedge clk);
         check_data({31'h0, busy}, 32'h0, "busy after ack");
         // a fault shown only while busy is dropped, so nothing follows
         repeat (4) begin
            @(negedge clk);
            check_data({31'h0, frame_word.valid}, 32'h0, "idle word");
         end
         $display("test %s code %h done", name, code);
      end
   endtask : run_frame

   // =========================================================
   // main sequence
   initial begin
      logic [16:0] fv;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check_data({23'h0, busy, last_code}, 32'h0, "reset");
      for (int i = 0; i < 17; i++) begin
         run_frame(17'h1 << i, 17'h0, "single");
      end
      for (int i = 0; i < 12; i++) begin
         fv = 17'(xs());
         if (fv == 17'h0) fv = 17'h10000;
         run_frame(fv, 17'h0, "priority");
      end
      run_frame(17'h10000, 17'h00001, "ignored while busy");
      run_frame(17'h18000, 17'h1FFFF, "all while busy");
      end_of_test();
   end
endmodule : machine_check_frame_bench
`default_nettype wire
